// File: rtl/dco_alarm_latch.sv
`timescale 1ns/1ps
module dco_alarm_latch
    import dco_pkg::*;
(
    input  logic             clk,
    input  logic             rst_n,
    input  logic [ALM_N-1:0] cond,
    input  logic [ALM_N-1:0] ack,
    output logic [ALM_N-1:0] pending
);
    for (genvar i = 0; i < ALM_N; i++) begin : g_alm
        // Condition holds the flag, so it also wins over an acknowledge
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pending[i] <= 1'b0;
            end else if (cond[i]) begin
                pending[i] <= 1'b1;
            end else if (ack[i]) begin
                pending[i] <= 1'b0;
            end
        end
    end
endmodule : dco_alarm_latch

// File: rtl/dco_pin_filter.sv
`timescale 1ns/1ps
module dco_pin_filter #(
    parameter int CYCLES = 4
) (
    input  logic clk,
    input  logic rst_n,
    input  logic pin,
    output logic level
);
    logic                      meta_q;
    logic                      sync_q;
    logic [$clog2(CYCLES+1)-1:0] cnt_q;

    // Reset to high: an open pin is pulled up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end

    // Level only moves after CYCLES stable samples, so contact bounce is ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            level <= 1'b1;
        end else if (sync_q == level) begin
            cnt_q <= '0;
        end else if (cnt_q == ($clog2(CYCLES+1))'(CYCLES - 1)) begin
            cnt_q <= '0;
            level <= sync_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : dco_pin_filter

// File: rtl/dco_pkg.sv
package dco_pkg;

    localparam int          CLK_HZ          = 20_000_000;
    localparam int          FILTER_TIME_US  = 1000;
    localparam int          FILTER_CYCLES   = FILTER_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          ACK_LOW_TIME_MS = 50;
    localparam int          ACK_LOW_CYCLES  = ACK_LOW_TIME_MS * (CLK_HZ / 1000);

    // Measurement codes: nominal full scale and the 110 percent level
    localparam logic [15:0] NOMINAL_CODE    = 16'h8000;
    localparam logic [15:0] THRESH_RESET    = 16'h8CCC;
    localparam logic [15:0] POWER_MAX       = 16'h8CCC;

    // Alarm indices
    localparam int          ALM_OV          = 0;
    localparam int          ALM_OC          = 1;
    localparam int          ALM_OP          = 2;
    localparam int          ALM_SF          = 3;
    localparam int          ALM_OT          = 4;
    localparam int          ALM_N           = 5;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL        = 12'h000;
    localparam logic [11:0] OFF_CMD         = 12'h004;
    localparam logic [11:0] OFF_STATUS      = 12'h008;
    localparam logic [11:0] OFF_EVENT       = 12'h00C;
    localparam logic [11:0] OFF_THR_V       = 12'h010;
    localparam logic [11:0] OFF_THR_I       = 12'h014;
    localparam logic [11:0] OFF_THR_P       = 12'h018;

    // CTRL fields
    localparam int          CTRL_INVERT     = 0;
    localparam int          CTRL_SOUND      = 1;
    localparam int          CTRL_RESTORE    = 2;
    localparam logic [2:0]  CTRL_RESET      = 3'h0;

    // CMD fields, write one to act
    localparam int          CMD_ON          = 0;
    localparam int          CMD_OFF         = 1;
    localparam int          CMD_ACK         = 2;

    // STATUS fields
    localparam int          ST_OUT_ON       = 0;
    localparam int          ST_LOCKED       = 1;
    localparam int          ST_REMOTE       = 2;
    localparam int          ST_ENABLE_LVL   = 3;
    localparam int          ST_PEND_LSB     = 8;
    localparam int          ST_COND_LSB     = 16;

    // EVENT fields, write one to clear
    localparam int          EV_REFUSED      = 0;

    typedef enum logic [2:0] {
        DCO_OFF    = 3'b001,
        DCO_ON     = 3'b010,
        DCO_LOCKED = 3'b100
    } dco_state_t;

endpackage : dco_pkg

// File: rtl/dco_top.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module dco_top
    import dco_pkg::*;
#(
    parameter int FILTER_LEN  = FILTER_CYCLES,
    parameter int ACK_LOW_LEN = ACK_LOW_CYCLES
) (
    // Clock and reset
    input  logic        CLK_SYS,
    input  logic        RST_N,
    // APB slave
    input  logic        PSEL,
    input  logic        PENABLE,
    input  logic        PWRITE,
    input  logic [11:0] PADDR,
    input  logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic        PREADY,
    output logic        PSLVERR,
    // Interface pins
    input  logic        STANDBY_INPUT,
    input  logic        REMOTE_SELECT_N,
    output logic        OVERVOLTAGE_OUT,
    output logic        THERMAL_SUPPLY_ALARM_OUTPUT,
    // Front panel
    input  logic        BTN_ONOFF,
    input  logic        BTN_ENTER,
    output logic        POPUP_REFUSED,
    output logic        ALARM_DISPLAY,
    output logic        ALARM_SOUND,
    // Power stage
    input  logic [15:0] MEAS_VOLTAGE,
    input  logic [15:0] MEAS_CURRENT,
    input  logic [15:0] MEAS_POWER,
    input  logic        SUPPLY_FAULT,
    input  logic        OVERTEMP_TRIP,
    output logic        DC_OUTPUT_ON
);
    import dco_pkg::*;

    logic             standby_f;
    logic             remote_n_f;
    logic             remote;
    logic             enable_lvl;
    logic [2:0]       ctrl_q;
    logic [15:0]      thr_v_q;
    logic [15:0]      thr_i_q;
    logic [15:0]      thr_p_q;
    logic             refused_q;
    logic             cmd_on;
    logic             cmd_off;
    logic             cmd_ack;
    logic [ALM_N-1:0] cond_q;
    logic [ALM_N-1:0] pending;
    logic [ALM_N-1:0] ack_vec;
    logic             any_pending;
    logic             sw_on_req;
    logic             sw_off_req;
    logic             toggle_req;
    logic             refuse_now;
    logic             manual_ack;
    logic             remote_ack;
    logic             en_prev_q;
    logic [$clog2(ACK_LOW_LEN+1)-1:0] low_cnt_q;
    logic             low_long_q;
    logic             sf_prev_q;
    logic             sf_was_on_q;
    logic             restore_evt;
    logic             restore_req_q;
    dco_state_t       state_q;
    dco_state_t       state_d;
    logic             wr_en;
    logic             rd_setup;
    logic             addr_ok;
    logic [31:0]      rdata_d;
    logic [15:0]      wdata_p;

    // Pin conditioning
    dco_pin_filter #(.CYCLES(FILTER_LEN)) u_standby_filter (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .pin   (STANDBY_INPUT),
        .level (standby_f)
    );

    dco_pin_filter #(.CYCLES(FILTER_LEN)) u_remote_filter (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .pin   (REMOTE_SELECT_N),
        .level (remote_n_f)
    );

    // Analog setpoints outside this block rely on this level being low
    assign remote     = !remote_n_f;
    // Normal: high or open enables; inverted swaps the meaning
    assign enable_lvl = standby_f ^ ctrl_q[CTRL_INVERT];

    // APB decode: no wait state, answer registered in the setup cycle
    assign wr_en    = PSEL && PENABLE && PREADY && PWRITE;
    assign rd_setup = PSEL && !PENABLE;
    assign addr_ok  = (PADDR == OFF_CTRL) || (PADDR == OFF_CMD) || (PADDR == OFF_STATUS) ||
                      (PADDR == OFF_EVENT) || (PADDR == OFF_THR_V) || (PADDR == OFF_THR_I) ||
                      (PADDR == OFF_THR_P);
    assign cmd_on   = wr_en && (PADDR == OFF_CMD) && PWDATA[CMD_ON];
    assign cmd_off  = wr_en && (PADDR == OFF_CMD) && PWDATA[CMD_OFF];
    assign cmd_ack  = wr_en && (PADDR == OFF_CMD) && PWDATA[CMD_ACK];
    assign wdata_p  = (PWDATA[15:0] > POWER_MAX) ? POWER_MAX : PWDATA[15:0];

    always_comb begin
        rdata_d = '0;
        case (PADDR)
            OFF_CTRL:   rdata_d[2:0] = ctrl_q;
            OFF_STATUS: begin
                rdata_d[ST_OUT_ON]     = (state_q == DCO_ON);
                rdata_d[ST_LOCKED]     = (state_q == DCO_LOCKED);
                rdata_d[ST_REMOTE]     = remote;
                rdata_d[ST_ENABLE_LVL] = enable_lvl;
                rdata_d[ST_PEND_LSB +: ALM_N] = pending;
                rdata_d[ST_COND_LSB +: ALM_N] = cond_q;
            end
            OFF_EVENT:  rdata_d[EV_REFUSED] = refused_q;
            OFF_THR_V:  rdata_d[15:0] = thr_v_q;
            OFF_THR_I:  rdata_d[15:0] = thr_i_q;
            OFF_THR_P:  rdata_d[15:0] = thr_p_q;
            default:    rdata_d = '0;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
        end else if (rd_setup) begin
            PREADY  <= 1'b1;
            PSLVERR <= !addr_ok;
            PRDATA  <= PWRITE ? 32'h0000_0000 : rdata_d;
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q  <= CTRL_RESET;
            thr_v_q <= THRESH_RESET;
            thr_i_q <= THRESH_RESET;
            thr_p_q <= THRESH_RESET;
        end else if (wr_en) begin
            case (PADDR)
                OFF_CTRL:  ctrl_q  <= PWDATA[2:0];
                OFF_THR_V: thr_v_q <= PWDATA[15:0];
                OFF_THR_I: thr_i_q <= PWDATA[15:0];
                OFF_THR_P: thr_p_q <= wdata_p;
                default:   ctrl_q  <= ctrl_q;
            endcase
        end
    end

    // Protection comparators; the temperature trip is a fixed hardware level
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cond_q <= '0;
        end else begin
            cond_q[ALM_OV] <= (MEAS_VOLTAGE >= thr_v_q);
            cond_q[ALM_OC] <= (MEAS_CURRENT >= thr_i_q);
            cond_q[ALM_OP] <= (MEAS_POWER >= thr_p_q);
            cond_q[ALM_SF] <= SUPPLY_FAULT;
            cond_q[ALM_OT] <= OVERTEMP_TRIP;
        end
    end

    // Remote acknowledge: enabling level back after a long enough low phase
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            en_prev_q  <= 1'b1;
            low_cnt_q  <= '0;
            low_long_q <= 1'b0;
        end else begin
            en_prev_q <= enable_lvl;
            if (enable_lvl) begin
                low_cnt_q  <= '0;
                low_long_q <= 1'b0;
            end else if (low_cnt_q == ($clog2(ACK_LOW_LEN+1))'(ACK_LOW_LEN - 1)) begin
                low_long_q <= 1'b1;
            end else begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
        end
    end

    assign remote_ack = remote && enable_lvl && !en_prev_q && low_long_q;
    assign manual_ack = !remote && any_pending && (BTN_ONOFF || BTN_ENTER);

    // Temporary supply loss may restore the output if the setting asks for it
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sf_prev_q   <= 1'b0;
            sf_was_on_q <= 1'b0;
        end else begin
            sf_prev_q <= cond_q[ALM_SF];
            if (cond_q[ALM_SF] && !sf_prev_q) begin
                sf_was_on_q <= (state_q == DCO_ON);
            end
        end
    end

    assign restore_evt = sf_prev_q && !cond_q[ALM_SF] && ctrl_q[CTRL_RESTORE] && sf_was_on_q;

    // Held until the alarm has cleared, so the output never comes back while an alarm is still shown
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            restore_req_q <= 1'b0;
        end else if (restore_evt) begin
            restore_req_q <= 1'b1;
        end else if (!any_pending && !(|cond_q)) begin
            restore_req_q <= 1'b0;
        end
    end

    always_comb begin
        ack_vec = {ALM_N{manual_ack || remote_ack || cmd_ack}};
        ack_vec[ALM_SF] = ack_vec[ALM_SF] || restore_evt;
    end

    dco_alarm_latch u_alarms (
        .clk     (CLK_SYS),
        .rst_n   (RST_N),
        .cond    (cond_q),
        .ack     (ack_vec),
        .pending (pending)
    );

    assign any_pending = |pending;

    // A panel press while an alarm is shown acknowledges (local mode only) instead of switching
    assign toggle_req = BTN_ONOFF && !any_pending;
    assign sw_on_req  = cmd_on || (toggle_req && state_q == DCO_OFF);
    assign sw_off_req = cmd_off || (toggle_req && state_q != DCO_OFF);
    assign refuse_now = !remote && state_q == DCO_OFF && sw_on_req && !sw_off_req &&
                        (!enable_lvl || any_pending);

    always_comb begin
        state_d = state_q;
        if (any_pending || (|cond_q)) begin
            state_d = DCO_OFF;
        end else if (restore_req_q && !remote) begin
            state_d = DCO_ON;
        end else if (remote) begin
            state_d = enable_lvl ? DCO_ON : DCO_OFF;
        end else begin
            case (state_q)
                DCO_OFF: begin
                    if (sw_on_req && !sw_off_req && enable_lvl) begin
                        state_d = DCO_ON;
                    end
                end
                DCO_ON: begin
                    if (sw_off_req) begin
                        state_d = DCO_OFF;
                    end else if (!enable_lvl) begin
                        state_d = DCO_LOCKED;
                    end
                end
                DCO_LOCKED: begin
                    if (sw_on_req || sw_off_req) begin
                        state_d = DCO_OFF;
                    end else if (enable_lvl) begin
                        state_d = DCO_ON;
                    end
                end
                default: state_d = DCO_OFF;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= DCO_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Refused switch-on: sticky flag for the digital side, pulse for the display
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            refused_q <= 1'b0;
        end else if (refuse_now) begin
            refused_q <= 1'b1;
        end else if (wr_en && PADDR == OFF_EVENT && PWDATA[EV_REFUSED]) begin
            refused_q <= 1'b0;
        end
    end

    // Output stage follows the next state, so a trip costs no extra cycle
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            DC_OUTPUT_ON <= 1'b0;
        end else begin
            DC_OUTPUT_ON <= (state_d == DCO_ON);
        end
    end

    // Display popup lasts one cycle per refused attempt
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            POPUP_REFUSED <= 1'b0;
        end else begin
            POPUP_REFUSED <= refuse_now;
        end
    end

    // Alarm indicators
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ALARM_DISPLAY               <= 1'b0;
            ALARM_SOUND                 <= 1'b0;
            OVERVOLTAGE_OUT             <= 1'b0;
            THERMAL_SUPPLY_ALARM_OUTPUT <= 1'b0;
        end else begin
            ALARM_DISPLAY               <= any_pending;
            ALARM_SOUND                 <= any_pending && ctrl_q[CTRL_SOUND];
            OVERVOLTAGE_OUT             <= pending[ALM_OV];
            THERMAL_SUPPLY_ALARM_OUTPUT <= pending[ALM_OT] || pending[ALM_SF];
        end
    end

endmodule : dco_top

// File: sim/dco_pins_model.sv
`timescale 1ns/1ps
module dco_pins_model #(
    parameter int LOW_CYCLES = 16
) (
    // Clock
    input  logic clk,
    // Contact controls
    input  logic close_sb,
    input  logic close_rem,
    input  logic ack_go,
    // Pins
    output logic sb_pin,
    output logic rem_n_pin
);
    int cnt = 0;

    // Contacts only sink to ground; an open contact reads high
    assign sb_pin    = !(close_sb || cnt > 0);
    assign rem_n_pin = !close_rem;

    // High, low for LOW_CYCLES, high again; low span kept above the minimum
    always @(posedge clk) begin
        if (ack_go && cnt == 0) begin
            cnt <= LOW_CYCLES;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : dco_pins_model

// File: sim/dco_top_sva.sv
`timescale 1ns/1ps
module dco_top_sva #(
    parameter int FILTER_LEN  = 4,
    parameter int ACK_LOW_LEN = 8
) (
    // Clock and reset
    input logic CLK_SYS,
    input logic RST_N,
    // Alarm causes
    input logic SUPPLY_FAULT,
    input logic OVERTEMP_TRIP,
    // Observed outputs
    input logic DC_OUTPUT_ON,
    input logic POPUP_REFUSED,
    input logic ALARM_DISPLAY,
    input logic ALARM_SOUND,
    input logic OVERVOLTAGE_OUT,
    input logic THERMAL_SUPPLY_ALARM_OUTPUT
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    // Five cycles leave room for the two register stages, cond_q and then DC_OUTPUT_ON, between the cause and the output
    a_ot_trip_off: assert property (OVERTEMP_TRIP [*5] |-> !DC_OUTPUT_ON)
        else $error("output on during overtemperature");
    a_sf_trip_off: assert property (SUPPLY_FAULT [*5] |-> !DC_OUTPUT_ON)
        else $error("output on during supply fail");
    a_pending_off: assert property (ALARM_DISPLAY [*2] |-> !DC_OUTPUT_ON)
        else $error("output on with alarm pending");
    a_pend_holds: assert property (OVERTEMP_TRIP [*5] ##0 ALARM_DISPLAY |=> ALARM_DISPLAY)
        else $error("alarm cleared while cause present");
    a_thermal_rise: assert property ($rose(OVERTEMP_TRIP) |-> ##[1:5] THERMAL_SUPPLY_ALARM_OUTPUT)
        else $error("thermal flag late");
    a_thermal_alarm: assert property (THERMAL_SUPPLY_ALARM_OUTPUT |-> ALARM_DISPLAY)
        else $error("thermal flag without alarm");
    a_ov_alarm: assert property (OVERVOLTAGE_OUT |-> ALARM_DISPLAY)
        else $error("overvoltage flag without alarm");
    a_sound_alarm: assert property (ALARM_SOUND |-> ALARM_DISPLAY)
        else $error("sound without alarm");
    a_refuse_off: assert property (POPUP_REFUSED |-> !DC_OUTPUT_ON)
        else $error("refusal while output on");

    c_on: cover property ($rose(DC_OUTPUT_ON));
    c_refused: cover property (POPUP_REFUSED);
    c_cleared: cover property ($fell(ALARM_DISPLAY));
endmodule : dco_top_sva

bind dco_top dco_top_sva #(
    .FILTER_LEN (FILTER_LEN),
    .ACK_LOW_LEN(ACK_LOW_LEN)
) i_dco_top_sva (
    .CLK_SYS                    (CLK_SYS),
    .RST_N                      (RST_N),
    .SUPPLY_FAULT               (SUPPLY_FAULT),
    .OVERTEMP_TRIP              (OVERTEMP_TRIP),
    .DC_OUTPUT_ON               (DC_OUTPUT_ON),
    .POPUP_REFUSED              (POPUP_REFUSED),
    .ALARM_DISPLAY              (ALARM_DISPLAY),
    .ALARM_SOUND                (ALARM_SOUND),
    .OVERVOLTAGE_OUT            (OVERVOLTAGE_OUT),
    .THERMAL_SUPPLY_ALARM_OUTPUT(THERMAL_SUPPLY_ALARM_OUTPUT)
);

// File: sim/dco_top_test.sv
`timescale 1ns/1ps
module dco_top_test;
    import dco_pkg::*;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        psel = 0, pen = 0, pwr = 0, perr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
    logic        pready, pslverr, sb_pin, rem_n, ov_out, th_out, popup, disp, snd, dc_on;
    logic        b_onoff = 0, b_enter = 0, sf = 0, ot = 0, close_sb = 0, close_rem = 0, ack_go = 0;
    logic [15:0] meas[3] = '{default: 16'h0000};
    logic [15:0] thr[3];
    logic [31:0] q_exp[$];
    int          q_src[$];
    int          bad_count = 0, samples_checked = 0, seed = 32'h67bec722, k;
    event        look;
    int          pops = 0;
    wire  [4:0]  outs = {snd, disp, th_out, ov_out, dc_on};

    dco_top #(.FILTER_LEN(4), .ACK_LOW_LEN(8)) i_dco_top (
        .CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STANDBY_INPUT(sb_pin),
        .REMOTE_SELECT_N(rem_n), .OVERVOLTAGE_OUT(ov_out), .THERMAL_SUPPLY_ALARM_OUTPUT(th_out),
        .BTN_ONOFF(b_onoff), .BTN_ENTER(b_enter), .POPUP_REFUSED(popup), .ALARM_DISPLAY(disp),
        .ALARM_SOUND(snd), .MEAS_VOLTAGE(meas[0]), .MEAS_CURRENT(meas[1]), .MEAS_POWER(meas[2]),
        .SUPPLY_FAULT(sf), .OVERTEMP_TRIP(ot), .DC_OUTPUT_ON(dc_on));
    dco_pins_model #(.LOW_CYCLES(16)) i_dco_pins_model (.clk(clk), .close_sb(close_sb),
        .close_rem(close_rem), .ack_go(ack_go), .sb_pin(sb_pin), .rem_n_pin(rem_n));

    initial forever #25 clk = ~clk;

    // Refusal popups last one cycle, so they are counted as they pass
    always @(posedge clk) pops <= pops + popup;

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        perr = pslverr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    task note(input int s, input logic [31:0] e);
        q_src.push_back(s);
        q_exp.push_back(e);
        ->look;
        #1;
    endtask : note
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0000_0000);
        note(0, e);
    endtask : rd
    task out_is(input logic [4:0] e);
        note(1, {27'h000_0000, e});
    endtask : out_is
    task cmd_out(input logic [31:0] c, input logic [4:0] e);
        apb(1, OFF_CMD, c);
        wt(3);
        out_is(e);
    endtask : cmd_out
    task press(input int b);
        @(posedge clk);
        b_onoff <= (b == 0);
        b_enter <= (b == 1);
        @(posedge clk);
        b_onoff <= 0;
        b_enter <= 0;
        wt(3);
    endtask : press
    task sb(input logic c);
        @(posedge clk);
        close_sb <= c;
        wt(14);
    endtask : sb
    task cmp(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : cmp
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // Checker side: oldest note against what is seen now
    initial forever begin
        @(look);
        cmp(q_src.pop_front() == 0 ? rdata : {27'h000_0000, outs}, q_exp.pop_front());
    end

    initial begin
        wt(5000);
        bad_count++;
        end_of_test();
    end

    initial begin
        wt(2);
        rst_n <= 1;
        out_is(5'h00);
        rd(OFF_CTRL, 32'h0000_0000);
        rd(OFF_THR_V, 32'h0000_8CCC);
        rd(OFF_THR_I, 32'h0000_8CCC);
        rd(OFF_THR_P, 32'h0000_8CCC);
        rd(12'h020, 32'h0000_0000);
        rdata = {31'h0000_0000, perr};
        note(0, 32'h0000_0001);
        thr[0] = (16'($random(seed)) & 16'h7FFF) | 16'h0100;
        thr[1] = 16'h8CCC;
        thr[2] = 16'h8CCC;
        apb(1, OFF_THR_V, {16'h0000, thr[0]});
        rd(OFF_THR_V, {16'h0000, thr[0]});
        apb(1, OFF_THR_P, 32'h0000_FFFF);
        rd(OFF_THR_P, 32'h0000_8CCC);
        for (k = 0; k < 3; k++) meas[k] <= 16'($random(seed)) & 16'h00FF;
        $display("test reset and thresholds done");
        cmd_out(32'h0000_0001, 5'h01);
        press(0);
        out_is(5'h00);
        cmd_out(32'h0000_0001, 5'h01);
        cmd_out(32'h0000_0002, 5'h00);
        sb(1);
        cmd_out(32'h0000_0001, 5'h00);
        rd(OFF_EVENT, 32'h0000_0001);
        apb(1, OFF_EVENT, 32'h0000_0001);
        rd(OFF_EVENT, 32'h0000_0000);
        apb(1, OFF_CTRL, 32'h0000_0001);
        cmd_out(32'h0000_0001, 5'h01);
        sb(0);
        out_is(5'h00);
        sb(1);
        out_is(5'h01);
        sb(0);
        press(0);
        sb(1);
        out_is(5'h00);
        apb(1, OFF_CTRL, 32'h0000_0000);
        sb(0);
        $display("test manual and lock done");
        @(posedge clk);
        close_rem <= 1;
        wt(14);
        out_is(5'h01);
        cmd_out(32'h0000_0002, 5'h01);
        press(0);
        out_is(5'h01);
        sb(1);
        out_is(5'h00);
        sb(0);
        out_is(5'h01);
        @(posedge clk);
        ot <= 1;
        wt(6);
        out_is(5'h0C);
        @(posedge clk);
        ot <= 0;
        wt(6);
        out_is(5'h0C);
        @(posedge clk);
        ack_go <= 1;
        @(posedge clk);
        ack_go <= 0;
        wt(40);
        out_is(5'h01);
        @(posedge clk);
        close_rem <= 0;
        wt(14);
        cmd_out(32'h0000_0002, 5'h00);
        $display("test remote done");
        apb(1, OFF_CTRL, 32'h0000_0002);
        for (k = 0; k < 5; k++) begin
            cmd_out(32'h0000_0001, 5'h01);
            @(posedge clk);
            if (k < 3) meas[k] <= thr[k];
            else if (k == 3) sf <= 1;
            else ot <= 1;
            wt(6);
            out_is({2'b11, k >= 3, k == 0, 1'b0});
            rd(OFF_STATUS, 32'h0000_0008 | (32'h0001_0100 << k));
            cmd_out(32'h0000_0004, {2'b11, k >= 3, k == 0, 1'b0});
            @(posedge clk);
            if (k < 3) meas[k] <= 16'h0000;
            sf <= 0;
            ot <= 0;
            wt(6);
            out_is({2'b11, k >= 3, k == 0, 1'b0});
            if (k == 4) cmd_out(32'h0000_0004, 5'h00);
            else press(k % 2);
            out_is(5'h00);
        end
        $display("test alarms done");
        apb(1, OFF_CTRL, 32'h0000_0004);
        cmd_out(32'h0000_0001, 5'h01);
        @(posedge clk);
        sf <= 1;
        wt(6);
        out_is(5'h0C);
        @(posedge clk);
        sf <= 0;
        wt(8);
        out_is(5'h01);
        rdata = pops;
        note(0, 32'h0000_0001);
        $display("test supply restore done");
        end_of_test();
    end
endmodule : dco_top_test
